// *** shared/uv_pkg.sv ***
package uv_pkg;

    // bus geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_RAILS = 7;
    localparam int RETRY_W = 4;
    localparam int STEP_W = 10;
    localparam int DB_W = 24;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_FAULT = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_RETRY = 8'h04;

    // reset values
    localparam logic [DATA_W-1:0] EVENT_RST = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] FAULT_RST = 8'h00;
    localparam logic [RETRY_W-1:0] RETRY_RST = 4'h0;
    localparam logic [NUM_RAILS-1:0] RAILS_OFF = 7'h00;
    localparam logic [NUM_RAILS-1:0] RAILS_ON = 7'h7F;

    // event and fault bit positions
    localparam int EV_WARN_BIT = 0;
    localparam int EV_FAULT_BIT = 1;
    localparam int EV_READY_BIT = 2;
    localparam int FAULT_SUPPLY_BIT = 0;

    // status bit positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_DB_BIT = 2;
    localparam int STAT_WARN_BIT = 3;
    localparam int STAT_ERR_BIT = 4;

    // timing
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int STEP_TIME_US = 100;
    localparam int STEP_CYCLES = (STEP_TIME_US * CLK_FREQ_HZ) / 1_000_000;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
    localparam int DEBOUNCE_TIME_MS = 1000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * (CLK_FREQ_HZ / 1000);

    // operating modes
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_SHUTDOWN = 2'b01,
        MODE_RESET = 2'b10,
        MODE_POWERUP = 2'b11
    } mode_t;

endpackage

// *** rtl/debounce_timer.sv ***
`timescale 1ns/1ps

module debounce_timer
    import uv_pkg::*;
#(
    parameter logic [DB_W-1:0] LENGTH = DB_W'(DEBOUNCE_CYCLES)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy
);

    logic [DB_W-1:0] count_reg;
    logic busy_reg;

    // restartable interval counter, blanking while running
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            busy_reg <= 1'b0;
        end
        else if (start)
        begin
            count_reg <= '0;
            busy_reg <= 1'b1;
        end
        else if (busy_reg)
        begin
            if (count_reg == LENGTH - DB_W'(1))
                busy_reg <= 1'b0;
            else
                count_reg <= count_reg + DB_W'(1);
        end
    end

    assign busy = busy_reg;

    restart_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> busy_reg && count_reg == '0)
        else $error("debounce counter did not restart");

    interval_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        busy_reg && !start && count_reg == LENGTH - DB_W'(1) |=> !busy_reg)
        else $error("debounce interval did not end on time");

endmodule // debounce_timer

// *** rtl/supply_uv_supervisor.sv ***
`timescale 1ns/1ps

// Overview of operation
// - supply warning drop sets event, raises interrupt
// - host clears event; interrupt drops if none
// - recovery above warning starts one-second debounce
// - warning comparator blanked during debounce, no warning event; error comparator not blanked
// - supply error sets fault flag, starts shutdown
// - error shutdown uses normal power-down order
// - error shutdown ends directly in reset
// - reset entry clears retry, keeps fault
// - stay in reset while supply below error
// - error gone: full cold-boot power-up
// - host reads all registers, writes only event, mask and fault
module supply_uv_supervisor
    import uv_pkg::*;
#(parameter logic [DB_W-1:0] DEBOUNCE_LEN = DB_W'(DEBOUNCE_CYCLES))
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SYSTEM_SUPPLY_BELOW_WARN,
    input wire logic SYSTEM_SUPPLY_BELOW_ERROR,
    input wire logic WDOG_RETRY_INC,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    output logic HOST_INTERRUPT_N,
    output logic [NUM_RAILS-1:0] REG_EN,
    output logic [1:0] MODE
);

    // address match used by write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    logic rst_meta_reg;
    logic rst_n;
    logic [1:0] cmp_meta_reg;
    logic [1:0] cmp_sync_reg;
    logic warn_s, err_s;
    logic warn_d_reg;
    logic warn_rise, warn_fall;
    logic db_busy;
    logic [DATA_W-1:0] event_reg, event_next, event_set, event_clr;
    logic [DATA_W-1:0] mask_reg;
    logic [DATA_W-1:0] fault_reg, fault_next, fault_clr;
    logic [RETRY_W-1:0] retry_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_n_reg;
    mode_t mode_reg;
    logic [NUM_RAILS-1:0] rails_reg;
    logic [STEP_W-1:0] step_reg;
    logic step_done, fault_set, enter_reset, boot_done;
    logic [DATA_W-1:0] status_val;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // two-flop synchronisers for the analog comparator outputs
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cmp_meta_reg[gi] <= 1'b0;
                    cmp_sync_reg[gi] <= 1'b0;
                end
                else
                begin
                    cmp_meta_reg[gi] <= gi == 0 ? SYSTEM_SUPPLY_BELOW_WARN
                                                : SYSTEM_SUPPLY_BELOW_ERROR;
                    cmp_sync_reg[gi] <= cmp_meta_reg[gi];
                end
            end
        end
    endgenerate

    assign warn_s = cmp_sync_reg[0];
    assign err_s = cmp_sync_reg[1];

    // edge history of the warning comparator
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            warn_d_reg <= 1'b0;
        else
            warn_d_reg <= warn_s;
    end

    assign warn_rise = warn_s && !warn_d_reg;
    assign warn_fall = !warn_s && warn_d_reg;

    // post-recovery blanking interval
    debounce_timer #(
        .LENGTH(DEBOUNCE_LEN)
    ) u_debounce (
        .clk(CLK),
        .rst_n(rst_n),
        .start(warn_fall),
        .busy(db_busy)
    );

    // event sources; a set in the clearing cycle survives
    always_comb
    begin
        event_set = '0;
        event_set[EV_WARN_BIT] = warn_rise && !db_busy;
        event_set[EV_FAULT_BIT] = fault_set;
        event_set[EV_READY_BIT] = boot_done;
        event_clr = (WR && hit(ADDR, ADDR_EVENT)) ? WDATA : '0;
        event_next = (event_reg & ~event_clr) | event_set;
    end

    // sticky event register
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            event_reg <= EVENT_RST;
        else
            event_reg <= event_next;
    end

    // interrupt mask, one bit masks one event
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            mask_reg <= MASK_RST;
        else if (WR && hit(ADDR, ADDR_MASK))
            mask_reg <= WDATA;
    end

    // level interrupt, low while any unmasked event stands
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= ~|(event_reg & ~mask_reg);
    end

    // supply error recognised only while rails are on or coming up
    assign fault_set = err_s
        && (mode_reg == MODE_ACTIVE || mode_reg == MODE_POWERUP);

    // fault record, write one to clear, set wins
    always_comb
    begin
        fault_clr = (WR && hit(ADDR, ADDR_FAULT)) ? WDATA : '0;
        fault_next = fault_reg & ~fault_clr;
        if (fault_set)
            fault_next[FAULT_SUPPLY_BIT] = 1'b1;
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            fault_reg <= FAULT_RST;
        else
            fault_reg <= fault_next;
    end

    // sequencer step timing
    assign step_done = step_reg == STEP_LAST;
    assign enter_reset = mode_reg == MODE_SHUTDOWN && step_done
        && rails_reg == RAILS_OFF;
    assign boot_done = mode_reg == MODE_POWERUP && step_done
        && rails_reg == RAILS_ON && !err_s;

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            step_reg <= '0;
        else if (mode_reg == MODE_ACTIVE || mode_reg == MODE_RESET
                 || fault_set || step_done)
            step_reg <= '0;
        else
            step_reg <= step_reg + STEP_W'(1);
    end

    // mode sequencer; starts in reset so the first pass is a cold boot
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg <= MODE_RESET;
            rails_reg <= RAILS_OFF;
        end
        else
        begin
            case (mode_reg)
                MODE_ACTIVE:
                begin
                    if (fault_set)
                        mode_reg <= MODE_SHUTDOWN;
                end
                MODE_POWERUP:
                begin
                    if (fault_set)
                        mode_reg <= MODE_SHUTDOWN;
                    else if (step_done && rails_reg == RAILS_ON)
                        mode_reg <= MODE_ACTIVE;
                    else if (step_done)
                        rails_reg <= {rails_reg[NUM_RAILS-2:0], 1'b1};
                end
                MODE_SHUTDOWN:
                begin
                    if (enter_reset)
                        mode_reg <= MODE_RESET;
                    else if (step_done)
                        rails_reg <= rails_reg >> 1;
                end
                MODE_RESET:
                begin
                    if (!err_s)
                        mode_reg <= MODE_POWERUP;
                end
                default:
                    mode_reg <= MODE_RESET;
            endcase
        end
    end

    // watchdog re-try counter, cleared on entering reset
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            retry_reg <= RETRY_RST;
        else if (enter_reset)
            retry_reg <= RETRY_RST;
        else if (WDOG_RETRY_INC && retry_reg != '1)
            retry_reg <= retry_reg + RETRY_W'(1);
    end

    // live status word
    always_comb
    begin
        status_val = '0;
        status_val[STAT_MODE_LSB +: 2] = mode_reg;
        status_val[STAT_DB_BIT] = db_busy;
        status_val[STAT_WARN_BIT] = warn_s;
        status_val[STAT_ERR_BIT] = err_s;
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= '0;
        else if (!RD)
            rdata_reg <= '0;
        else if (hit(ADDR, ADDR_EVENT))
            rdata_reg <= event_reg;
        else if (hit(ADDR, ADDR_MASK))
            rdata_reg <= mask_reg;
        else if (hit(ADDR, ADDR_FAULT))
            rdata_reg <= fault_reg;
        else if (hit(ADDR, ADDR_STATUS))
            rdata_reg <= status_val;
        else if (hit(ADDR, ADDR_RETRY))
            rdata_reg <= {{(DATA_W-RETRY_W){1'b0}}, retry_reg};
        else
            rdata_reg <= '0;
    end

    assign RDATA = rdata_reg;
    assign HOST_INTERRUPT_N = irq_n_reg;
    assign REG_EN = rails_reg;
    assign MODE = mode_reg;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);
    sequence shut_to_reset_s;
        mode_reg == MODE_SHUTDOWN ##1 mode_reg == MODE_RESET;
    endsequence
    sequence armed_drop_s;
        warn_rise && !db_busy && !mask_reg[EV_WARN_BIT];
    endsequence
    warn_irq_a: assert property (armed_drop_s |-> ##2 !HOST_INTERRUPT_N)
        else $error("unmasked warning did not raise interrupt");
    irq_release_a: assert property (
        (event_reg & ~mask_reg) == '0 |=> HOST_INTERRUPT_N)
        else $error("interrupt held with no unmasked event");
    debounce_start_a: assert property (warn_fall |=> db_busy)
        else $error("recovery did not start debounce");
    blank_warn_a: assert property (
        db_busy && !event_reg[EV_WARN_BIT] |=> !event_reg[EV_WARN_BIT])
        else $error("warning event raised during debounce");
    error_flag_a: assert property (
        err_s && mode_reg == MODE_ACTIVE
        |=> fault_reg[FAULT_SUPPLY_BIT] && mode_reg == MODE_SHUTDOWN)
        else $error("supply error did not log fault and shut down");
    rail_order_a: assert property (
        mode_reg == MODE_SHUTDOWN |=> (rails_reg & ~$past(rails_reg)) == '0
        && (rails_reg & (rails_reg + NUM_RAILS'(1))) == '0)
        else $error("shutdown rail order broken");
    reset_direct_a: assert property (
        mode_reg == MODE_SHUTDOWN
        |=> mode_reg == MODE_SHUTDOWN || mode_reg == MODE_RESET)
        else $error("error shutdown left to a non-reset mode");
    retry_clear_a: assert property (
        shut_to_reset_s |-> retry_reg == '0
        && ($past(fault_reg[FAULT_SUPPLY_BIT]) ? fault_reg[FAULT_SUPPLY_BIT]
            || $past(WR) : 1'b1))
        else $error("reset entry did not clear retry or lost fault");
    hold_reset_a: assert property (
        mode_reg == MODE_RESET && err_s |=> mode_reg == MODE_RESET)
        else $error("left reset while supply below error");
    cold_boot_a: assert property (
        mode_reg == MODE_RESET && !err_s
        |=> mode_reg == MODE_POWERUP && rails_reg == RAILS_OFF)
        else $error("reset exit did not start full power-up");
    read_status_a: assert property (
        RD && hit(ADDR, ADDR_STATUS) |=> RDATA == $past(status_val))
        else $error("status read returned wrong data");

endmodule // supply_uv_supervisor

// *** test/supply_model.sv ***
`timescale 1ns/1ps

module supply_model
    import uv_pkg::*;
(
    input wire logic [1:0] level,
    output logic below_warn,
    output logic below_error
);
    // comparators read low while the supply sits above both thresholds
    logic warn_q = 1'b0;
    logic err_q = 1'b0;

    // analog edges land off the clock grid
    always @(level)
    begin
        warn_q <= #37 (level != 2'd0);
        err_q <= #37 (level == 2'd2);
    end

    // one driver per comparator output
    assign below_warn = warn_q;
    assign below_error = err_q;
endmodule // supply_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module testbench
    import uv_pkg::*;
;
    localparam int DB = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic retry_inc = 1'b0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [1:0] level = 2'd0;
    logic below_warn;
    logic below_error;
    logic [7:0] rdata;
    logic irq_n;
    logic [6:0] reg_en;
    logic [1:0] mode;
    logic [7:0] d;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    supply_model sup (.level(level), .below_warn(below_warn),
        .below_error(below_error));

    supply_uv_supervisor #(.DEBOUNCE_LEN(DB_W'(DB))) dut (
        .CLK(clk), .RSTN(rst_n), .SYSTEM_SUPPLY_BELOW_WARN(below_warn),
        .SYSTEM_SUPPLY_BELOW_ERROR(below_error),
        .WDOG_RETRY_INC(retry_inc), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .HOST_INTERRUPT_N(irq_n),
        .REG_EN(reg_en), .MODE(mode));

    // 10 mhz clock
    always #50 clk = ~clk;

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // read data stand one cycle only, then zero
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(negedge clk);
        `CHK(rdata, 8'h00)
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_mode(input logic [1:0] m);
        int i;
        for (i = 0; i < 20000 && mode !== m; i++)
            @(negedge clk);
        `CHK(mode, m)
    endtask

    // rails move one at a time: down from the top, up from bit 0
    task automatic watch_rails(input logic up);
        logic [6:0] e;
        int i;
        int n;
        e = up ? RAILS_OFF : RAILS_ON;
        for (n = 0; n < 7; n++)
        begin
            for (i = 0; i < 1500 && reg_en === e; i++)
                @(negedge clk);
            e = up ? {e[5:0], 1'b1} : (e >> 1);
            `CHK(reg_en, e)
        end
    endtask

    task automatic t_boot();
        wait_mode(MODE_POWERUP);
        watch_rails(1'b1);
        wait_mode(MODE_ACTIVE);
        cyc(3);
        `CHK(irq_n, 1'b0)
        rc(ADDR_EVENT, 8'h04);
        rc(ADDR_STATUS, 8'h00);
        wr(8'h07, 8'hFF);
        rc(8'h07, 8'h00);
        wr(ADDR_EVENT, 8'h04);
        cyc(3);
        `CHK(irq_n, 1'b1)
    endtask

    task automatic t_warn();
        level <= 2'd1;
        cyc(8);
        `CHK(irq_n, 1'b0)
        rc(ADDR_EVENT, 8'h01);
        wr(ADDR_MASK, 8'h01);
        cyc(3);
        `CHK(irq_n, 1'b1)
        rc(ADDR_MASK, 8'h01);
        wr(ADDR_MASK, 8'h00);
        cyc(3);
        `CHK(irq_n, 1'b0)
        wr(ADDR_EVENT, 8'h01);
        cyc(3);
        `CHK(irq_n, 1'b1)
        rc(ADDR_EVENT, 8'h00);
    endtask

    task automatic t_debounce();
        level <= 2'd0;
        cyc(5);
        rd(ADDR_STATUS, d);
        `CHK(d & 8'h04, 8'h04)
        level <= 2'd1;
        cyc(8);
        `CHK(irq_n, 1'b1)
        rc(ADDR_EVENT, 8'h00);
        level <= 2'd0;
        cyc(40);
        rd(ADDR_STATUS, d);
        `CHK(d & 8'h04, 8'h04)
        cyc(60);
        rd(ADDR_STATUS, d);
        `CHK(d & 8'h04, 8'h00)
        level <= 2'd1;
        cyc(8);
        `CHK(irq_n, 1'b0)
    endtask

    task automatic t_error();
        repeat (3)
        begin
            @(posedge clk);
            retry_inc <= 1'b1;
            @(posedge clk);
            retry_inc <= 1'b0;
        end
        wr(ADDR_RETRY, 8'hFF);
        rc(ADDR_RETRY, 8'h03);
        level <= 2'd2;
        cyc(6);
        `CHK(mode, MODE_SHUTDOWN)
        rc(ADDR_FAULT, 8'h01);
        wr(ADDR_EVENT, 8'h01);
        cyc(3);
        `CHK(irq_n, 1'b0)
        watch_rails(1'b0);
        wait_mode(MODE_RESET);
        rc(ADDR_RETRY, 8'h00);
        rc(ADDR_FAULT, 8'h01);
        // reset mode, both comparators below, debounce idle
        rc(ADDR_STATUS, 8'h1A);
        cyc(3000);
        `CHK(mode, MODE_RESET)
        `CHK(reg_en, RAILS_OFF)
        level <= 2'd0;
        wait_mode(MODE_POWERUP);
        watch_rails(1'b1);
        wait_mode(MODE_ACTIVE);
        rc(ADDR_EVENT, 8'h06);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(mode, MODE_RESET)
        `CHK(reg_en, RAILS_OFF)
        `CHK(irq_n, 1'b1)
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_boot();
        t_warn();
        t_debounce();
        t_error();
        summarize();
    end
endmodule // testbench
